/* logic/rtc_port_pkg.sv */
// Constants shared by the two-wire target port of the clock device
package rtc_port_pkg;
   // Target addresses, upper seven bits of the first byte
   localparam logic [6:0] ADDR_CLOCK    = 7'h6F;   // 1101111b
   localparam logic [6:0] ADDR_SRAM     = 7'h57;   // 1010111b
   localparam logic       DIR_READ      = 1'b1;    // Direction bit value
   // Pointer and memory
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam int         SRAM_DEPTH    = 128;
   localparam int         SRAM_AW       = 7;
   localparam logic [7:0] BEYOND_DATA   = 8'h00;   // Read past 7Fh
   localparam logic [2:0] BIT_LAST      = 3'h7;
   // Power-up quiet time, start conditions ignored meanwhile
   localparam int         POWERUP_NS    = 1000;
   localparam int         CLK_PERIOD_PS = 4000;
   localparam int         POWERUP_CYC   =
      (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int         PWR_W         = 9;
   // Clock-space write FIFO shape
   localparam int         FIFO_WIDTH    = 16;
   localparam int         FIFO_DEPTH    = 32;
   // Serial engine states
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h2,
      ST_WADR      = 4'h3,
      ST_WADR_ACK  = 4'h4,
      ST_WDATA     = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA     = 4'h7,
      ST_RDATA_ACK = 4'h8,
      ST_IGNORE    = 4'h9
   } port_state_e;
endpackage : rtc_port_pkg

/* logic/rtc_serial_target_port.sv */
// Two-wire serial target port with user SRAM and clock-space write FIFO
// Behaviour
// RULE1: bytes shift most significant bit first
// RULE2: data changes only while clock low
// RULE3: data line released after power-up
// RULE4: ignore bus until start; none during power-up
// RULE5: stop returns interface to idle
// RULE6: transmitter releases after eight; receiver acks ninth
// RULE7: ack matched address, word address, write data; clock-space data not acked while the FIFO is full
// RULE8: master acks read bytes wanting more
// RULE9: address 1101111b clock space, 1010111b SRAM
// RULE10: direction bit one reads, zero writes
// RULE11: ack only when address matches
// RULE12: mismatch: no ack, ignore until start
// RULE13: word pointer resets to 00h
// RULE14: dummy-write address equals read address
// RULE15: single write: start, address, word, data, stop
// RULE16: burst writes stored consecutively, each acked; a full FIFO leaves clock-space bytes unacked
// RULE17: pointer never wraps to page start
// RULE18: read uses dummy write then repeated start
// RULE19: send bytes while master keeps acking
// RULE20: pointer loaded from word address, advances
// RULE21: master stops reading at section end
// RULE22: SRAM holds 128 bytes, no unlock needed
`timescale 1ns/1ps

module rtc_write_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,      // Core clock
   input  wire logic             rst_n,    // Async reset, active low
   input  wire logic             inValid,  // Push request
   output logic                  inReady,  // Space available
   input  wire logic [WIDTH-1:0] inData,   // Pushed word
   output logic                  outValid, // Word available
   input  wire logic             outReady, // Consumer takes word
   output logic [WIDTH-1:0]      outData   // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   wire              doPush;
   wire              doPop;

   // Extra pointer bit separates full from empty
   assign inReady  = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
   assign outValid = wrPtr_r != rdPtr_r;
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;
   assign outData  = mem[rdPtr_r[AW-1:0]];

   // Storage has no reset, pointers define validity
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   // Pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         wrPtr_r <= wrPtr_r + (AW+1)'(doPush);
         rdPtr_r <= rdPtr_r + (AW+1)'(doPop);
      end
   end
endmodule : rtc_write_fifo

module rtc_serial_target_port (
   input  wire logic       clk,       // Core clock, 250 MHz
   input  wire logic       rst_n,     // Async reset, active low
   input  wire logic       sclIn,     // Serial clock pin level
   input  wire logic       sdaIn,     // Serial data pin level
   output logic            sdaOut,    // Data drive value, always low
   output logic            sdaOe_n,   // Low while pulling data low
   output logic [7:0]      regRdAddr, // Clock-space read location
   input  wire logic [7:0] regRdData, // Clock-space read byte
   output logic            wrValid,   // Clock-space write pending
   input  wire logic       wrReady,   // Clock space accepts write
   output logic [7:0]      wrAddr,    // Clock-space write location
   output logic [7:0]      wrData     // Clock-space write byte
);
   rtc_port_pkg::port_state_e state_r, state_nxt;
   logic             sclM_r, sclS_r, sclP_r;
   logic             sdaM_r, sdaS_r, sdaP_r;
   logic [rtc_port_pkg::PWR_W-1:0] pwrCnt_r;
   logic             pwrOk_r;
   logic [7:0]       shReg_r, shReg_nxt;
   logic [2:0]       bitCnt_r, bitCnt_nxt;
   logic             byteDone_r, byteDone_nxt;
   logic             sdaDrv_r, sdaDrv_nxt;
   logic [7:0]       ptr_r, ptr_nxt;
   logic             isRead_r, isRead_nxt;
   logic             isSram_r, isSram_nxt;
   logic             ackSeen_r, ackSeen_nxt;
   logic             sramWe;
   logic             fifoPush;
   logic             fifoReady;
   logic [7:0]       sram [0:rtc_port_pkg::SRAM_DEPTH-1];

   // Pin synchronisers, first stage read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclM_r <= 1'b1;
         sclS_r <= 1'b1;
         sclP_r <= 1'b1;
         sdaM_r <= 1'b1;
         sdaS_r <= 1'b1;
         sdaP_r <= 1'b1;
      end else begin
         sclM_r <= sclIn;
         sclS_r <= sclM_r;
         sclP_r <= sclS_r;
         sdaM_r <= sdaIn;
         sdaS_r <= sdaM_r;
         sdaP_r <= sdaS_r;
      end
   end

   // Line events; start and stop need a steady high clock
   wire sclRise  = sclS_r && !sclP_r;
   wire sclFall  = !sclS_r && sclP_r;
   wire startDet = sclS_r && sclP_r && sdaP_r && !sdaS_r;
   wire stopDet  = sclS_r && sclP_r && !sdaP_r && sdaS_r;

   // Address decode of the first byte
   wire matchClock = shReg_r[7:1] == rtc_port_pkg::ADDR_CLOCK; // [RULE9]
   wire matchSram  = shReg_r[7:1] == rtc_port_pkg::ADDR_SRAM;  // [RULE9]
   wire addrMatch  = matchClock || matchSram;                 // [RULE11]
   wire ptrInSram  = !ptr_r[7];                               // [RULE22]
   wire rxState    = state_r == rtc_port_pkg::ST_ADDR ||
                     state_r == rtc_port_pkg::ST_WADR ||
                     state_r == rtc_port_pkg::ST_WDATA;
   wire cntState   = rxState || state_r == rtc_port_pkg::ST_RDATA;
   wire lastBit    = bitCnt_r == rtc_port_pkg::BIT_LAST;

   // Read source: SRAM by pointer, else the clock space byte
   wire [7:0] sramByte = ptrInSram ? sram[ptr_r[6:0]] :
                                     rtc_port_pkg::BEYOND_DATA;
   wire [7:0] rdByte   = isSram_r ? sramByte : regRdData;     // [RULE20]

   // Power-up quiet period; bus events are not looked at before it ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrCnt_r <= '0;
         pwrOk_r  <= 1'b0;
      end else if (!pwrOk_r) begin
         pwrCnt_r <= pwrCnt_r + 1'b1;
         pwrOk_r  <= pwrCnt_r ==
                     rtc_port_pkg::PWR_W'(rtc_port_pkg::POWERUP_CYC - 1);
      end
   end

   // Serial engine next state
   always_comb begin
      state_nxt    = state_r;
      shReg_nxt    = shReg_r;
      bitCnt_nxt   = bitCnt_r;
      byteDone_nxt = byteDone_r;
      sdaDrv_nxt   = sdaDrv_r;
      ptr_nxt      = ptr_r;
      isRead_nxt   = isRead_r;
      isSram_nxt   = isSram_r;
      ackSeen_nxt  = ackSeen_r;
      sramWe       = 1'b0;
      fifoPush     = 1'b0;
      if (!pwrOk_r) begin
         state_nxt  = rtc_port_pkg::ST_IDLE;                  // [RULE4]
         sdaDrv_nxt = 1'b0;                                   // [RULE3]
      end else if (stopDet) begin
         state_nxt  = rtc_port_pkg::ST_IDLE;                  // [RULE5]
         sdaDrv_nxt = 1'b0;
      end else if (startDet) begin
         state_nxt    = rtc_port_pkg::ST_ADDR;                // [RULE4]
         bitCnt_nxt   = '0;
         byteDone_nxt = 1'b0;
         sdaDrv_nxt   = 1'b0;
      end else if (sclRise) begin
         if (cntState) begin
            bitCnt_nxt   = bitCnt_r + 1'b1;
            byteDone_nxt = lastBit;
         end
         if (rxState) begin
            shReg_nxt = {shReg_r[6:0], sdaS_r};               // [RULE1]
         end
         if (state_r == rtc_port_pkg::ST_RDATA_ACK) begin
            ackSeen_nxt = !sdaS_r;                            // [RULE19]
         end
      end else if (sclFall) begin                             // [RULE2]
         case (state_r)
            rtc_port_pkg::ST_ADDR: begin
               if (byteDone_r) begin
                  byteDone_nxt = 1'b0;
                  if (addrMatch) begin
                     sdaDrv_nxt = 1'b1;                       // [RULE7]
                     isRead_nxt = shReg_r[0] ==
                                  rtc_port_pkg::DIR_READ;     // [RULE10]
                     isSram_nxt = matchSram;
                     state_nxt  = rtc_port_pkg::ST_ADDR_ACK;
                  end else begin
                     state_nxt  = rtc_port_pkg::ST_IGNORE;    // [RULE12]
                  end
               end
            end
            rtc_port_pkg::ST_ADDR_ACK: begin
               if (isRead_r) begin
                  shReg_nxt  = rdByte;                        // [RULE13]
                  sdaDrv_nxt = !rdByte[7];                    // [RULE1]
                  state_nxt  = rtc_port_pkg::ST_RDATA;
               end else begin
                  sdaDrv_nxt = 1'b0;                          // [RULE6]
                  state_nxt  = rtc_port_pkg::ST_WADR;
               end
            end
            rtc_port_pkg::ST_WADR: begin
               if (byteDone_r) begin
                  byteDone_nxt = 1'b0;
                  ptr_nxt      = shReg_r;                     // [RULE20]
                  sdaDrv_nxt   = 1'b1;                        // [RULE7]
                  state_nxt    = rtc_port_pkg::ST_WADR_ACK;
               end
            end
            rtc_port_pkg::ST_WDATA: begin
               if (byteDone_r) begin
                  byteDone_nxt = 1'b0;
                  // A full FIFO refuses the byte rather than lose it
                  if (isSram_r || fifoReady) begin
                     sdaDrv_nxt = 1'b1;                       // [RULE16]
                     ptr_nxt    = ptr_r + 8'h01;              // [RULE17]
                     sramWe     = isSram_r && ptrInSram;      // [RULE22]
                     fifoPush   = !isSram_r;
                     state_nxt  = rtc_port_pkg::ST_WDATA_ACK;
                  end else begin
                     state_nxt  = rtc_port_pkg::ST_IGNORE;
                  end
               end
            end
            rtc_port_pkg::ST_WADR_ACK,
            rtc_port_pkg::ST_WDATA_ACK: begin
               sdaDrv_nxt = 1'b0;                             // [RULE6]
               state_nxt  = rtc_port_pkg::ST_WDATA;
            end
            rtc_port_pkg::ST_RDATA: begin
               if (byteDone_r) begin
                  byteDone_nxt = 1'b0;
                  sdaDrv_nxt   = 1'b0;                        // [RULE6]
                  ptr_nxt      = ptr_r + 8'h01;               // [RULE20]
                  state_nxt    = rtc_port_pkg::ST_RDATA_ACK;
               end else begin
                  shReg_nxt  = {shReg_r[6:0], 1'b0};
                  sdaDrv_nxt = !shReg_r[6];                   // [RULE1]
               end
            end
            rtc_port_pkg::ST_RDATA_ACK: begin
               if (ackSeen_r) begin
                  shReg_nxt  = rdByte;                        // [RULE19]
                  sdaDrv_nxt = !rdByte[7];
                  state_nxt  = rtc_port_pkg::ST_RDATA;
               end else begin
                  sdaDrv_nxt = 1'b0;
                  state_nxt  = rtc_port_pkg::ST_IGNORE;
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // Serial engine registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= rtc_port_pkg::ST_IDLE;
         shReg_r    <= '0;
         bitCnt_r   <= '0;
         byteDone_r <= 1'b0;
         sdaDrv_r   <= 1'b0;                                  // [RULE3]
         ptr_r      <= rtc_port_pkg::PTR_RESET;               // [RULE13]
         isRead_r   <= 1'b0;
         isSram_r   <= 1'b0;
         ackSeen_r  <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         shReg_r    <= shReg_nxt;
         bitCnt_r   <= bitCnt_nxt;
         byteDone_r <= byteDone_nxt;
         sdaDrv_r   <= sdaDrv_nxt;
         ptr_r      <= ptr_nxt;
         isRead_r   <= isRead_nxt;
         isSram_r   <= isSram_nxt;
         ackSeen_r  <= ackSeen_nxt;
      end
   end

   // User SRAM, battery-backed in the real part, so no reset
   always_ff @(posedge clk) begin
      if (sramWe) begin
         sram[ptr_r[6:0]] <= shReg_r;                         // [RULE16]
      end
   end

   // Clock-space writes leave through the FIFO
   rtc_write_fifo #(
      .WIDTH (rtc_port_pkg::FIFO_WIDTH),
      .DEPTH (rtc_port_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (fifoPush),
      .inReady  (fifoReady),
      .inData   ({ptr_r, shReg_r}),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  ({wrAddr, wrData})
   );

   // Open-drain data pin: only ever pulls low
   assign sdaOut    = 1'b0;
   assign sdaOe_n   = !sdaDrv_r;                               // [RULE6]
   assign regRdAddr = ptr_r;

   wire busQuiet = !startDet && !stopDet;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_DRIVE_CLOCK_LOW: assert property ( // [RULE2]
      $changed(sdaDrv_r) && $past(busQuiet) && $past(pwrOk_r) |-> !sclS_r)
      else $error("Data drive changed while clock high");
   AST_POWERUP_QUIET: assert property ( // [RULE4]
      !pwrOk_r |=> state_r == rtc_port_pkg::ST_IDLE && sdaOe_n)
      else $error("Bus activity during power-up");
   AST_STOP_IDLE: assert property ( // [RULE5]
      pwrOk_r && stopDet |=> state_r == rtc_port_pkg::ST_IDLE && !sdaDrv_r)
      else $error("Stop did not return to idle");
   AST_ACK_MATCH: assert property ( // [RULE11]
      state_r == rtc_port_pkg::ST_ADDR && sclFall && byteDone_r &&
      addrMatch && busQuiet
      |=> state_r == rtc_port_pkg::ST_ADDR_ACK && !sdaOe_n)
      else $error("Matching address not acknowledged");
   AST_IGNORE_RELEASED: assert property ( // [RULE12]
      state_r == rtc_port_pkg::ST_IGNORE |-> sdaOe_n)
      else $error("Data driven while ignoring bus");
   AST_PTR_LOAD: assert property ( // [RULE20]
      state_r == rtc_port_pkg::ST_WADR && sclFall && byteDone_r && busQuiet
      |=> ptr_r == $past(shReg_r))
      else $error("Pointer not loaded from word address");
   AST_MSB_FIRST: assert property ( // [RULE1]
      state_r == rtc_port_pkg::ST_RDATA && sclFall && !byteDone_r &&
      busQuiet && pwrOk_r |=> sdaDrv_r == !$past(shReg_r[6]))
      else $error("Read bit order wrong");
   AST_READ_ADVANCE: assert property ( // [RULE17]
      state_r == rtc_port_pkg::ST_RDATA && sclFall && byteDone_r &&
      busQuiet && pwrOk_r |=> ptr_r == $past(ptr_r) + 8'h01 && sdaOe_n)
      else $error("Pointer did not advance after read byte");
   AST_WRITE_RELEASE: assert property ( // [RULE6]
      state_r == rtc_port_pkg::ST_WDATA_ACK && sclFall && busQuiet &&
      pwrOk_r |=> sdaOe_n ##1 state_r == rtc_port_pkg::ST_WDATA)
      else $error("Acknowledge not released");

   COV_SRAM_WRITE: cover property (sramWe);
   COV_CLOCK_WRITE: cover property (fifoPush);
   COV_READ_MORE: cover property (
      state_r == rtc_port_pkg::ST_RDATA_ACK && ackSeen_r && sclFall);
   COV_NO_MATCH: cover property (state_r == rtc_port_pkg::ST_IGNORE);
endmodule : rtc_serial_target_port

/* tb/i2c_master_model.sv */
// Behavioural two-wire bus master that drives the target port
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic clk,     // Bench clock, used to realign frames
   output logic      sclOut,  // Serial clock, stands high between frames
   output logic      sdaLow,  // High while the master pulls data low
   input  wire logic sdaLine  // Resolved data wire level
);
   localparam real Q = 31.25; // Quarter of a 125 ns bit

   // Idle bus: both lines released
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   // Start or repeated start; the offset keeps pin edges off clk edges
   task automatic startCond();
      @(negedge clk);
      #0.3;
      sdaLow = 1'b0;
      #Q;
      sclOut = 1'b1;
      #Q;
      sdaLow = 1'b1;
      #Q;
      sclOut = 1'b0;
      #Q;
   endtask : startCond

   // Data rises while the clock is high
   task automatic stopCond();
      sdaLow = 1'b1;
      #Q;
      sclOut = 1'b1;
      #Q;
      sdaLow = 1'b0;
      #Q;
   endtask : stopCond

   // Data set only in the low phase of the clock
   task automatic bitOut(input logic b);
      sdaLow = !b;
      #Q;
      sclOut = 1'b1;
      #(2 * Q);
      sclOut = 1'b0;
      #Q;
   endtask : bitOut

   // Released line, sampled in mid high phase
   task automatic bitIn(output logic b);
      sdaLow = 1'b0;
      #Q;
      sclOut = 1'b1;
      #Q;
      b = sdaLine;
      #Q;
      sclOut = 1'b0;
      #Q;
   endtask : bitIn

   // Eight bits out, then the ninth clock for the target's ack
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic nak;
      for (int i = 7; i >= 0; i--) begin
         bitOut(d[i]);
      end
      bitIn(nak);
      ack = !nak;
   endtask : sendByte

   // Eight bits in, then ack when more bytes are wanted
   task automatic recvByte(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bitIn(d[i]);
      end
      bitOut(!more);
   endtask : recvByte
endmodule : i2c_master_model

/* tb/tb_rtc_serial_target_port.sv */
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
module tb_rtc_serial_target_port;
   logic        clk;
   logic        rst_n;
   logic        sclOut;
   logic        sdaLow;
   wire         sdaLine;
   logic        sdaOut;
   logic        sdaOe_n;
   logic [7:0]  regRdAddr;
   logic [7:0]  regRdData;
   logic        wrValid;
   logic        wrReady = 1'b0;
   logic [7:0]  wrAddr;
   logic [7:0]  wrData;
   logic        stall = 1'b1;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [7:0]  sram [0:255];
   logic [15:0] expQ [$];
   logic [15:0] popQ [$];
   logic        ack;
   logic [7:0]  rd;

   // Clock-space contents seen by the port
   function automatic logic [7:0] clkByte(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction : clkByte

   // Open-drain wire with pull-up; either party may pull low
   assign sdaLine = (sdaLow || (!sdaOe_n && !sdaOut)) ? 1'b0 : 1'b1;
   assign regRdData = clkByte(regRdAddr);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   rtc_serial_target_port dut (
      .clk(clk), .rst_n(rst_n), .sclIn(sclOut), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .regRdAddr(regRdAddr),
      .regRdData(regRdData), .wrValid(wrValid), .wrReady(wrReady),
      .wrAddr(wrAddr), .wrData(wrData)
   );

   i2c_master_model bus (
      .clk(clk), .sclOut(sclOut), .sdaLow(sdaLow), .sdaLine(sdaLine)
   );

   // Consumer of clock-space writes; stalls on demand
   always @(negedge clk) begin
      wrReady <= stall ? 1'b0 : 1'(($urandom % 4) != 0);
   end
   always @(posedge clk) begin
      if (wrValid === 1'b1 && wrReady)
         popQ.push_back({wrAddr, wrData});
   end

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic results();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task automatic addrPhase(logic [6:0] dev, logic [7:0] wa);
      bus.startCond();
      bus.sendByte({dev, 1'b0}, ack);
      check("addr ack", 16'h1, {15'h0, ack});
      bus.sendByte(wa, ack);
      check("word ack", 16'h1, {15'h0, ack});
   endtask : addrPhase

   // Burst write; a full FIFO refuses the byte and all after it
   task automatic writeBurst(logic [6:0] dev, logic [7:0] wa, int n);
      logic [7:0] a;
      logic [7:0] d;
      logic       ok;
      a = wa;
      ok = 1'b1;
      addrPhase(dev, wa);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         if (dev == rtc_port_pkg::ADDR_CLOCK && stall &&
             expQ.size() - popQ.size() >= rtc_port_pkg::FIFO_DEPTH)
            ok = 1'b0;
         bus.sendByte(d, ack);
         check("data ack", {15'h0, ok}, {15'h0, ack});
         if (ok && dev == rtc_port_pkg::ADDR_SRAM && a < 8'h80)
            sram[a] = d;
         if (ok && dev == rtc_port_pkg::ADDR_CLOCK)
            expQ.push_back({a, d});
         a++;
      end
      bus.stopCond();
      check("idle after stop", 16'h1, {15'h0, sdaOe_n});
   endtask : writeBurst

   // Random read: dummy write with the same address, then read phase
   task automatic readBurst(logic [6:0] dev, logic [7:0] wa, int n);
      logic [7:0] a;
      logic [7:0] e;
      a = wa;
      addrPhase(dev, wa);
      bus.startCond();
      bus.sendByte({dev, 1'b1}, ack);
      check("read addr ack", 16'h1, {15'h0, ack});
      for (int i = 0; i < n; i++) begin
         bus.recvByte(i < n - 1, rd);
         e = (dev == rtc_port_pkg::ADDR_SRAM) ? sram[a] : clkByte(a);
         check("read byte", {8'h0, e}, {8'h0, rd});
         a++;
      end
      bus.stopCond();
   endtask : readBurst

   initial begin
      #390000;
      mismatches++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end

   initial begin
      rst_n = 1'b0;
      void'($urandom(44209));
      foreach (sram[i]) sram[i] = rtc_port_pkg::BEYOND_DATA;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("released at power-up", 16'h1, {15'h0, sdaOe_n});
      // Start inside the quiet time is ignored
      bus.startCond();
      bus.sendByte({rtc_port_pkg::ADDR_SRAM, 1'b0}, ack);
      check("quiet ack", 16'h0, {15'h0, ack});
      bus.stopCond();
      repeat (50) @(negedge clk);
      // Current-address read starts at 00h and advances
      bus.startCond();
      bus.sendByte({rtc_port_pkg::ADDR_CLOCK, 1'b1}, ack);
      check("cur addr ack", 16'h1, {15'h0, ack});
      for (int i = 0; i < 2; i++) begin
         bus.recvByte(i == 0, rd);
         check("cur read", {8'h0, clkByte(8'(i))}, {8'h0, rd});
      end
      bus.stopCond();
      // Foreign address: no ack, later bytes ignored
      bus.startCond();
      bus.sendByte({7'h12, 1'b0}, ack);
      check("foreign ack", 16'h0, {15'h0, ack});
      bus.sendByte(8'h00, ack);
      check("ignored ack", 16'h0, {15'h0, ack});
      bus.stopCond();
      // Random SRAM bursts read back
      repeat (4) begin
         int b;
         int n;
         b = $urandom_range(0, 120);
         n = $urandom_range(1, 8);
         writeBurst(rtc_port_pkg::ADDR_SRAM, 8'(b), n);
         readBurst(rtc_port_pkg::ADDR_SRAM, 8'(b), n);
      end
      // Across the end of SRAM, and clock space across FFh
      writeBurst(rtc_port_pkg::ADDR_SRAM, 8'h7E, 3);
      readBurst(rtc_port_pkg::ADDR_SRAM, 8'h7E, 3);
      readBurst(rtc_port_pkg::ADDR_CLOCK, 8'hFE, 3);
      // Reset in mid-run: line released, pointer back to 00h from 01h
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("released after reset", 16'h1, {15'h0, sdaOe_n});
      repeat (260) @(negedge clk);
      bus.startCond();
      bus.sendByte({rtc_port_pkg::ADDR_CLOCK, 1'b1}, ack);
      check("reset addr ack", 16'h1, {15'h0, ack});
      bus.recvByte(1'b0, rd);
      check("reset read", {8'h0, clkByte(8'h00)}, {8'h0, rd});
      bus.stopCond();
      // Clock-space writes: running consumer, then fill until refused
      stall = 1'b0;
      writeBurst(rtc_port_pkg::ADDR_CLOCK, 8'h20, 5);
      repeat (20) @(negedge clk);
      stall = 1'b1;
      repeat (4) @(negedge clk);
      writeBurst(rtc_port_pkg::ADDR_CLOCK, 8'h40, 34);
      stall = 1'b0;
      for (int i = 0; i < 2000 && popQ.size() < expQ.size(); i++)
         @(negedge clk);
      check("fifo words", 16'(expQ.size()), 16'(popQ.size()));
      foreach (expQ[i])
         check("fifo word", expQ[i],
               (i < popQ.size()) ? popQ[i] : 16'hX);
      results();
   end
endmodule : tb_rtc_serial_target_port
